// ==== hw/alu_params.svh ====
`ifndef ALU_PARAMS_SVH
`define ALU_PARAMS_SVH
`define ALU_ALL_ONES 8'hff
`define ALU_ZERO_BYTE 8'h00
`define ALU_ONE_BYTE 8'h01
`define ALU_SIGN_BIT 7
`define ALU_HALF_BIT 3
`define ALU_WORD_SIGN_BIT 15
`define ALU_CYCLES_ONE 2'h1
`define ALU_CYCLES_TWO 2'h2
`define ALU_FLAGS_RESET 6'h00
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`endif

// ==== hw/alu_pkg.sv ====
package alu_pkg;
    typedef enum logic [4:0] {
        add_op = 5'h00,
        add_with_carry_op = 5'h01,
        word_add_immediate_op = 5'h02,
        subtract_op = 5'h03,
        subtract_constant_op = 5'h04,
        subtract_with_borrow_op = 5'h05,
        subtract_constant_with_borrow_op = 5'h06,
        word_subtract_immediate_op = 5'h07,
        and_op = 5'h08,
        and_constant_op = 5'h09,
        or_op = 5'h0a,
        or_constant_op = 5'h0b,
        exclusive_or_op = 5'h0c,
        ones_complement_op = 5'h0d,
        twos_complement_op = 5'h0e,
        set_mask_bits_op = 5'h0f,
        clear_mask_bits_op = 5'h10,
        increment_op = 5'h11,
        decrement_op = 5'h12,
        zero_minus_check_op = 5'h13,
        clear_register_op = 5'h14,
        load_all_ones_op = 5'h15,
        unsigned_multiply_op = 5'h16,
        signed_multiply_op = 5'h17,
        mixed_sign_multiply_op = 5'h18,
        fractional_unsigned_multiply_op = 5'h19,
        fractional_signed_multiply_op = 5'h1a,
        fractional_mixed_multiply_op = 5'h1b
    } alu_op_type;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_second = 2'b01
    } alu_state_type;
endpackage : alu_pkg

// ==== hw/byte_alu.sv ====
`timescale 1ns/1ps
`include "alu_params.svh"
// What this block does
// RQ1 - Add two registers without carry; flags Z C N V H; one clock.
// RQ2 - Add two registers plus carry; flags Z C N V H; one clock.
// RQ3 - Add constant to register pair; flags Z C N V S; two clocks.
// RQ4 - Subtract register or constant; flags Z C N V H; one clock.
// RQ5 - Subtract operand and carry; flags Z C N V H; one clock.
// RQ6 - Subtract constant from register pair; flags Z C N V S; two clocks.
// RQ7 - AND with register or constant; flags Z N V S only; one clock.
// RQ8 - OR with register or constant; flags Z N V S only; one clock.
// RQ9 - OR a constant mask into the register; flags Z N V; one clock.
// RQ10 - AND register with inverted mask; flags Z N V; one clock.
// RQ11 - AND register with itself unchanged; flags Z N V; one clock.
// RQ12 - Integer multiplies put product in lowest pair; flags Z C; two clocks.
// RQ13 - Fractional multiplies shift product left one; flags Z C; two clocks.
// RQ14 - Ones and twos complement in one clock with arithmetic flags.
// RQ15 - Increment and decrement in one clock; carry left unchanged.
// RQ16 - Exclusive OR, clear via self XOR, load all ones flagless; one clock.
module byte_alu (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Request from the decoder.
    input wire logic op_valid,
    input wire alu_pkg::alu_op_type op_code,
    input wire logic [7:0] dest_val,
    input wire logic [7:0] src_val,
    input wire logic [7:0] dest_high_val,
    // Answer to the register file.
    output logic busy,
    output logic result_valid,
    output logic [7:0] result_low,
    output logic [7:0] result_high,
    output logic result_is_pair,
    output logic result_to_product,
    output logic [1:0] cycle_count,
    // Status flags.
    output logic [5:0] flags
);
    import alu_pkg::*;

    // ----------------------------------------
    // Byte operations.
    // ----------------------------------------
    wire logic carry_in = flags[`FLAG_C];
    wire logic is_sub = op_code inside {subtract_op, subtract_constant_op, subtract_with_borrow_op,
        subtract_constant_with_borrow_op, twos_complement_op};
    wire logic use_carry = op_code inside {add_with_carry_op, subtract_with_borrow_op,
        subtract_constant_with_borrow_op};
    wire logic [7:0] sub_a = (op_code == twos_complement_op) ? `ALU_ZERO_BYTE : dest_val;
    wire logic [7:0] sub_b = (op_code == twos_complement_op) ? dest_val : src_val;
    wire logic cin = use_carry & carry_in;
    wire logic [8:0] add_sum = {1'b0, dest_val} + {1'b0, src_val} + {8'h00, cin};
    wire logic [8:0] sub_diff = {1'b0, sub_a} - {1'b0, sub_b} - {8'h00, cin};
    wire logic [4:0] add_half = {1'b0, dest_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
    wire logic [4:0] sub_half = {1'b0, sub_a[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, cin};
    wire logic [7:0] inc_val = dest_val + `ALU_ONE_BYTE;
    wire logic [7:0] dec_val = dest_val - `ALU_ONE_BYTE;
    wire logic [7:0] add_res = add_sum[7:0];
    wire logic [7:0] sub_res = sub_diff[7:0];
    wire logic add_ovf = (dest_val[`ALU_SIGN_BIT] == src_val[`ALU_SIGN_BIT]) &&
        (add_res[`ALU_SIGN_BIT] != dest_val[`ALU_SIGN_BIT]);
    wire logic sub_ovf = (sub_a[`ALU_SIGN_BIT] != sub_b[`ALU_SIGN_BIT]) &&
        (sub_res[`ALU_SIGN_BIT] != sub_a[`ALU_SIGN_BIT]);

    // ----------------------------------------
    // Word and multiply operations.
    // ----------------------------------------
    wire logic [15:0] pair_val = {dest_high_val, dest_val};
    wire logic [16:0] word_sum = {1'b0, pair_val} + {9'h000, src_val};
    wire logic [16:0] word_diff = {1'b0, pair_val} - {9'h000, src_val};
    wire logic is_word = (op_code == word_add_immediate_op) || (op_code == word_subtract_immediate_op);
    wire logic is_mul = op_code inside {unsigned_multiply_op, signed_multiply_op, mixed_sign_multiply_op,
        fractional_unsigned_multiply_op, fractional_signed_multiply_op, fractional_mixed_multiply_op};
    wire logic is_frac = op_code inside {fractional_unsigned_multiply_op, fractional_signed_multiply_op,
        fractional_mixed_multiply_op};
    wire logic a_signed = op_code inside {signed_multiply_op, mixed_sign_multiply_op,
        fractional_signed_multiply_op, fractional_mixed_multiply_op};
    wire logic b_signed = (op_code == signed_multiply_op) || (op_code == fractional_signed_multiply_op);
    wire logic signed [8:0] mul_a = {a_signed & dest_val[`ALU_SIGN_BIT], dest_val};
    wire logic signed [8:0] mul_b = {b_signed & src_val[`ALU_SIGN_BIT], src_val};
    wire logic signed [17:0] mul_full = mul_a * mul_b;
    wire logic [15:0] mul_raw = mul_full[15:0];
    wire logic [15:0] mul_prod = is_frac ? {mul_raw[14:0], 1'b0} : mul_raw;

    // ----------------------------------------
    // Result and flag selection.
    // ----------------------------------------
    logic [15:0] res_nxt;
    logic [5:0] flags_nxt;
    logic [7:0] r8;
    logic [15:0] r16;
    always_comb begin
        res_nxt = {8'h00, dest_val};
        flags_nxt = flags;
        r8 = dest_val;
        r16 = pair_val;
        unique case (op_code)
            add_op, add_with_carry_op: begin
                r8 = add_res; // [RQ1] [RQ2]
                flags_nxt[`FLAG_C] = add_sum[8];
                flags_nxt[`FLAG_H] = add_half[4];
                flags_nxt[`FLAG_V] = add_ovf;
            end
            subtract_op, subtract_constant_op, subtract_with_borrow_op, subtract_constant_with_borrow_op,
            twos_complement_op: begin
                r8 = sub_res; // [RQ4] [RQ5] [RQ14]
                flags_nxt[`FLAG_C] = sub_diff[8];
                flags_nxt[`FLAG_H] = sub_half[4];
                flags_nxt[`FLAG_V] = sub_ovf;
            end
            ones_complement_op: begin
                r8 = `ALU_ALL_ONES - dest_val; // [RQ14]
                flags_nxt[`FLAG_C] = 1'b1;
                flags_nxt[`FLAG_V] = 1'b0;
            end
            and_op, and_constant_op: begin
                r8 = dest_val & src_val; // [RQ7]
                flags_nxt[`FLAG_V] = 1'b0;
            end
            or_op, or_constant_op, set_mask_bits_op: begin
                r8 = dest_val | src_val; // [RQ8] [RQ9]
                flags_nxt[`FLAG_V] = 1'b0;
            end
            clear_mask_bits_op: begin
                r8 = dest_val & (`ALU_ALL_ONES - src_val); // [RQ10]
                flags_nxt[`FLAG_V] = 1'b0;
            end
            zero_minus_check_op: begin
                r8 = dest_val & dest_val; // [RQ11]
                flags_nxt[`FLAG_V] = 1'b0;
            end
            exclusive_or_op, clear_register_op: begin
                r8 = (op_code == clear_register_op) ? (dest_val ^ dest_val) : (dest_val ^ src_val); // [RQ16]
                flags_nxt[`FLAG_V] = 1'b0;
            end
            increment_op: begin
                r8 = inc_val; // [RQ15]
                flags_nxt[`FLAG_V] = (dest_val == 8'h7f);
            end
            decrement_op: begin
                r8 = dec_val; // [RQ15]
                flags_nxt[`FLAG_V] = (dest_val == 8'h80);
            end
            load_all_ones_op: r8 = `ALU_ALL_ONES; // [RQ16]
            word_add_immediate_op: begin
                r16 = word_sum[15:0]; // [RQ3]
                flags_nxt[`FLAG_C] = word_sum[16];
                flags_nxt[`FLAG_V] = ~pair_val[`ALU_WORD_SIGN_BIT] & r16[`ALU_WORD_SIGN_BIT];
            end
            word_subtract_immediate_op: begin
                r16 = word_diff[15:0]; // [RQ6]
                flags_nxt[`FLAG_C] = word_diff[16];
                flags_nxt[`FLAG_V] = pair_val[`ALU_WORD_SIGN_BIT] & ~r16[`ALU_WORD_SIGN_BIT];
            end
            default: begin
                r16 = mul_prod; // [RQ12] [RQ13]
                flags_nxt[`FLAG_C] = is_frac ? mul_raw[`ALU_WORD_SIGN_BIT] : mul_prod[`ALU_WORD_SIGN_BIT];
            end
        endcase
        if (is_word || is_mul) begin
            res_nxt = r16;
            flags_nxt[`FLAG_Z] = (r16 == 16'h0000);
            if (is_word) begin
                flags_nxt[`FLAG_N] = r16[`ALU_WORD_SIGN_BIT]; // [RQ3] [RQ6]
                flags_nxt[`FLAG_S] = flags_nxt[`FLAG_N] ^ flags_nxt[`FLAG_V];
            end
        end else begin
            res_nxt = {8'h00, r8};
            if (op_code != load_all_ones_op) begin
                flags_nxt[`FLAG_Z] = (r8 == `ALU_ZERO_BYTE);
                flags_nxt[`FLAG_N] = r8[`ALU_SIGN_BIT];
                flags_nxt[`FLAG_S] = flags_nxt[`FLAG_N] ^ flags_nxt[`FLAG_V];
            end
        end
    end

    // ----------------------------------------
    // Sequencing.
    // ----------------------------------------
    // Two-clock operations hold busy for one extra cycle so the decoder stalls.
    alu_state_type state_r;
    logic [15:0] hold_r;
    logic hold_pair_r;
    logic hold_prod_r;
    wire logic two_clock = is_word || is_mul;
    wire logic take = op_valid && (state_r == st_idle);
    assign busy = (state_r == st_second);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= st_idle;
            flags <= `ALU_FLAGS_RESET;
            hold_r <= 16'h0000;
            hold_pair_r <= 1'b0;
            hold_prod_r <= 1'b0;
            result_valid <= 1'b0;
            result_low <= `ALU_ZERO_BYTE;
            result_high <= `ALU_ZERO_BYTE;
            result_is_pair <= 1'b0;
            result_to_product <= 1'b0;
            cycle_count <= 2'h0;
        end else begin
            result_valid <= 1'b0;
            if (take) begin
                flags <= flags_nxt;
                hold_r <= res_nxt;
                hold_pair_r <= is_word;
                hold_prod_r <= is_mul;
                if (two_clock) begin
                    state_r <= st_second; // [RQ3] [RQ6] [RQ12] [RQ13]
                end else begin
                    result_valid <= 1'b1; // [RQ1]
                    result_low <= res_nxt[7:0];
                    result_high <= res_nxt[15:8];
                    result_is_pair <= 1'b0;
                    result_to_product <= 1'b0;
                    cycle_count <= `ALU_CYCLES_ONE;
                end
            end else if (state_r == st_second) begin
                state_r <= st_idle;
                result_valid <= 1'b1;
                result_low <= hold_r[7:0];
                result_high <= hold_r[15:8];
                result_is_pair <= hold_pair_r;
                result_to_product <= hold_prod_r;
                cycle_count <= `ALU_CYCLES_TWO;
            end
        end
    end
endmodule : byte_alu

// ==== tb/byte_alu_checker.sv ====
`timescale 1ns/1ps
`include "alu_params.svh"
module byte_alu_checker (
    // Request.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire alu_pkg::alu_op_type op_code,
    input wire logic [7:0] dest_val,
    // Answer.
    input wire logic busy,
    input wire logic result_valid,
    input wire logic [7:0] result_low,
    input wire logic result_is_pair,
    input wire logic result_to_product,
    input wire logic [1:0] cycle_count,
    input wire logic [5:0] flags
);
    import alu_pkg::*;
    logic take;
    logic word;
    logic mul;
    logic keep_ch;
    assign take = op_valid && !busy;
    assign word = op_code inside {word_add_immediate_op, word_subtract_immediate_op};
    assign mul = op_code >= unsigned_multiply_op;
    assign keep_ch = op_code inside {[and_op:exclusive_or_op], [set_mask_bits_op:clear_register_op]};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence busy_gap;
        busy && !result_valid;
    endsequence
    sequence long_done;
        result_valid && !busy && cycle_count == `ALU_CYCLES_TWO;
    endsequence
    chk_one_clock_done: assert property (take && !word && !mul |=> result_valid && cycle_count == 2'h1)
        else $error("one-clock op not answered next cycle");
    chk_two_clock_done: assert property (take && (word || mul) |=> busy_gap ##1 long_done)
        else $error("two-clock op timing wrong");
    chk_busy_single: assert property (busy |=> !busy)
        else $error("busy longer than one cycle");
    chk_pair_dest: assert property (take && word |=> ##1 result_is_pair && !result_to_product)
        else $error("word result not routed to pair");
    chk_product_dest: assert property (take && mul |=> ##1 result_to_product && !result_is_pair)
        else $error("product not routed to lowest pair");
    chk_logic_keeps_carry: assert property (take && keep_ch |=> $stable(flags[`FLAG_C]) && $stable(flags[`FLAG_H]))
        else $error("carry or half carry changed");
    chk_ones_flagless: assert property (take && op_code == load_all_ones_op |=> $stable(flags) && result_low == 8'hff)
        else $error("load all ones wrong");
    chk_test_unchanged: assert property (take && op_code == zero_minus_check_op |=> result_low == $past(dest_val))
        else $error("test op changed value");
    chk_mul_keeps_rest: assert property (take && mul |=> $stable(flags[5:2]))
        else $error("multiply touched other flags");
endmodule : byte_alu_checker
bind byte_alu byte_alu_checker chk (.clk_sys, .rst_n, .op_valid, .op_code, .dest_val, .busy, .result_valid,
    .result_low, .result_is_pair, .result_to_product, .cycle_count, .flags);

// ==== tb/regfile_model.sv ====
`timescale 1ns/1ps
module regfile_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Answer from the datapath.
    input wire logic result_valid,
    input wire logic result_to_product,
    input wire logic [7:0] result_low,
    input wire logic [7:0] result_high,
    // Lowest register pair.
    output logic [7:0] product_low_r,
    output logic [7:0] product_high_r
);
    // Only the product pair is kept, since nothing else is read back.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            product_low_r <= 8'h00;
            product_high_r <= 8'h00;
        end else if (result_valid && result_to_product) begin
            product_low_r <= result_low;
            product_high_r <= result_high;
        end
    end
endmodule : regfile_model

// ==== tb/byte_alu_tb.sv ====
`timescale 1ns/1ps
`include "alu_params.svh"
module byte_alu_tb;
    import alu_pkg::*;
    typedef struct packed {logic [15:0] res; logic [5:0] fl; logic [5:0] mask; logic [1:0] kind;} note_type;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    alu_op_type op_code = add_op;
    logic [7:0] dest_val = 8'h00;
    logic [7:0] src_val = 8'h00;
    logic [7:0] dest_high_val = 8'h00;
    logic busy, result_valid, result_is_pair, result_to_product, exp_c;
    logic [7:0] result_low, result_high, product_low, product_high, a, b;
    logic [1:0] cycle_count;
    logic [5:0] flags;
    alu_op_type op;
    note_type notes[$];
    note_type seen;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    always #5 clk_sys = ~clk_sys;
    byte_alu uut (.clk_sys, .rst_n, .op_valid, .op_code, .dest_val, .src_val, .dest_high_val, .busy,
        .result_valid, .result_low, .result_high, .result_is_pair, .result_to_product, .cycle_count, .flags);
    regfile_model regs (.clk_sys, .rst_n, .result_valid, .result_to_product, .result_low, .result_high,
        .product_low_r(product_low), .product_high_r(product_high));
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    function automatic note_type predict(alu_op_type o, logic [7:0] x0, y0, h, logic c);
        logic [7:0] x, y, l;
        logic [8:0] r;
        logic [4:0] hc;
        logic [15:0] w, p;
        logic s, ci, v, cw, vw, com;
        s = o inside {[subtract_op:subtract_constant_with_borrow_op], twos_complement_op, decrement_op};
        ci = o inside {add_with_carry_op, subtract_with_borrow_op, subtract_constant_with_borrow_op} ? c : 1'b0;
        x = o == twos_complement_op ? 8'h00 : x0;
        y = o == twos_complement_op ? x0 : o inside {increment_op, decrement_op} ? 8'h01 : y0;
        r = s ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
        hc = s ? {1'b0, x[3:0]} - y[3:0] - ci : {1'b0, x[3:0]} + y[3:0] + ci;
        v = (s ? x[7] != y[7] : x[7] == y[7]) && r[7] != x[7];
        com = o == ones_complement_op;
        l = o inside {or_op, or_constant_op, set_mask_bits_op} ? x0 | y0 : o == clear_mask_bits_op ? x0 & ~y0
            : o inside {exclusive_or_op, clear_register_op} ? x0 ^ y0 : com ? ~x0 : x0 & y0;
        w = o == word_add_immediate_op ? {h, x0} + y0 : {h, x0} - y0;
        cw = o == word_add_immediate_op ? h[7] & ~w[15] : ~h[7] & w[15];
        vw = o == word_add_immediate_op ? ~h[7] & w[15] : h[7] & ~w[15];
        if (o inside {unsigned_multiply_op, fractional_unsigned_multiply_op}) p = x0 * y0;
        else if (o inside {signed_multiply_op, fractional_signed_multiply_op}) p = $signed(x0) * $signed(y0);
        else p = $signed(x0) * $signed({1'b0, y0});
        if (o inside {word_add_immediate_op, word_subtract_immediate_op}) return '{w, {1'b0, w[15] ^ vw, vw, w[15],
            w == 16'h0000, cw}, 6'h1f, 2'd1};
        if (o >= unsigned_multiply_op) begin
            w = o >= fractional_unsigned_multiply_op ? p << 1 : p;
            return '{w, {4'h0, w == 16'h0000, p[15]}, 6'h03, 2'd2};
        end
        if (o == load_all_ones_op) return '{16'h00ff, 6'h00, 6'h00, 2'd0};
        if (com || o inside {[and_op:exclusive_or_op], set_mask_bits_op, clear_mask_bits_op,
            zero_minus_check_op, clear_register_op}) return '{{8'h00, l}, {2'b01 & l[7], 1'b0, l[7], l == 8'h00, com},
            {5'h0f, com}, 2'd0};
        return '{{8'h00, r[7:0]}, {hc[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]}, o inside {increment_op,
            decrement_op} ? 6'h1e : o inside {subtract_with_borrow_op, subtract_constant_with_borrow_op} ? 6'h3d : 6'h3f, 2'd0};
    endfunction : predict
    task automatic issue(alu_op_type o, logic [7:0] x, y, h);
        note_type n;
        n = predict(o, x, y, h, exp_c);
        exp_c = n.mask[`FLAG_C] ? n.fl[`FLAG_C] : exp_c;
        notes.push_back(n);
        op_valid = 1'b1;
        op_code = o;
        dest_val = x;
        src_val = y;
        dest_high_val = h;
        @(posedge clk_sys);
        #1;
        if (n.kind != 2'd0) begin
            // Offered in the busy cycle, so it must be dropped without a trace.
            op_code = alu_op_type'($urandom_range(27));
            op_valid = 1'($urandom_range(1));
            @(posedge clk_sys);
            #1;
        end
    endtask : issue
    task automatic idle();
        op_valid = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : idle
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            end_of_test();
        end else if (rst_n && result_valid === 1'b1) begin
            seen = notes.size() > 0 ? notes.pop_front() : '{16'hdead, 6'h3f, 6'h3f, 2'd3};
            cmp("result", seen.kind == 2'd0 ? seen.res & 16'h00ff : seen.res, {seen.kind == 2'd0 ? 8'h00
                : result_high, result_low});
            cmp("flags", seen.fl & seen.mask, flags & seen.mask);
            cmp("route", {seen.kind, seen.kind != 2'd0 ? 2'h2 : 2'h1}, {result_to_product, result_is_pair,
                cycle_count});
        end
    end
    initial begin
        exp_c = 1'b0;
        void'($urandom(32'h3234));
        repeat (4) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        issue(add_op, 8'hff, 8'h01, 8'h00);
        issue(add_with_carry_op, 8'h7f, 8'h00, 8'h00);
        issue(subtract_constant_op, 8'h00, 8'h01, 8'h00);
        issue(subtract_constant_with_borrow_op, 8'h80, 8'h00, 8'h00);
        issue(word_add_immediate_op, 8'hff, 8'h01, 8'hff);
        issue(word_subtract_immediate_op, 8'h00, 8'h01, 8'h80);
        issue(fractional_signed_multiply_op, 8'h80, 8'h80, 8'h00);
        issue(mixed_sign_multiply_op, 8'hff, 8'hff, 8'h00);
        idle();
        cmp("product pair", 16'hff01, {product_high, product_low});
        for (int pass = 0; pass < 2; pass++) begin
            repeat (300) begin
                op = alu_op_type'($urandom_range(27));
                a = 8'($urandom_range(255));
                b = op inside {zero_minus_check_op, clear_register_op} ? a : 8'($urandom_range(op inside
                    {word_add_immediate_op, word_subtract_immediate_op} ? 63 : 255));
                issue(op, a, b, 8'($urandom_range(255)));
            end
            idle();
            cmp("pending results", 16'h0000, 16'(notes.size()));
            rst_n = 1'b0;
            exp_c = 1'b0;
            repeat (2) @(posedge clk_sys);
            #1;
            rst_n = 1'b1;
            cmp("reset outputs", 16'h0000, {8'h00, flags, result_valid, busy});
        end
        end_of_test();
    end
endmodule : byte_alu_tb
